// ==== xcs_pkg.sv ====
package xcs_pkg;
	// register byte addresses on the control bus
	localparam logic [7:0] XCS_OFS_CTRL   = 8'h00;
	localparam logic [7:0] XCS_OFS_STAT   = 8'h04;
	localparam logic [7:0] XCS_OFS_MASK   = 8'h08;
	localparam logic [7:0] XCS_OFS_IOAPIC = 8'h0c;
	// control register fields
	localparam int XCS_B_RTC    = 0;
	localparam int XCS_B_KBD    = 1;
	localparam int XCS_B_BIOSWR = 2;
	localparam int XCS_B_MOUSE  = 4;
	localparam int XCS_B_FPU    = 5;
	localparam int XCS_B_LBIOS  = 6;
	localparam int XCS_B_XBIOS  = 7;
	localparam int XCS_B_IOAPIC = 8;
	localparam logic [15:0] XCS_CTRL_RST  = 16'h0003;
	localparam logic [15:0] XCS_CTRL_WMSK = 16'h01f7;
	// ioapic region default base, two locations 16 bytes apart
	localparam logic [31:0] XCS_IOAPIC_RST = 32'hfec0_0000;
	localparam logic [31:0] XCS_IOAPIC_STEP = 32'h0000_0010;
	// bios windows
	localparam logic [31:0] XCS_XBIOS_LO = 32'hfff8_0000;
	localparam logic [31:0] XCS_XBIOS_HI = 32'hfffd_ffff;
	localparam logic [31:0] XCS_LBIOS_LO = 32'h000e_0000;
	localparam logic [31:0] XCS_LBIOS_HI = 32'h000e_ffff;
	localparam logic [31:0] XCS_ABIOS_LO = 32'hfffe_0000;
	localparam logic [31:0] XCS_ABIOS_HI = 32'hfffe_ffff;
	// i/o ports
	localparam logic [15:0] XCS_KBD_P0 = 16'h0060;
	localparam logic [15:0] XCS_KBD_P1 = 16'h0064;
	localparam logic [15:0] XCS_RTC_LO = 16'h0070;
	localparam logic [15:0] XCS_RTC_HI = 16'h0077;
	localparam logic [3:0]  XCS_LA_TOP = 4'hf;
	// status bit positions
	localparam int XCS_ST_FPU  = 0;
	localparam int XCS_ST_DEC  = 1;
	localparam int XCS_ST_W    = 2;
	localparam logic [1:0] XCS_RESP_OK  = 2'b00;
	localparam logic [1:0] XCS_RESP_ERR = 2'b10;
	typedef enum logic [1:0] {XCS_CYC_MEMRD, XCS_CYC_MEMWR, XCS_CYC_IORD, XCS_CYC_IOWR} xcs_cyc_t;
endpackage

// ==== xcs_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module xcs_sync
	import xcs_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} xcs_sync_t;
	xcs_sync_t st_r;
	xcs_sync_t st_nxt;

	// first stage feeds only the second
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d_i;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_o = st_r.s2;
endmodule

// ==== xcs_axil.sv ====
`timescale 1ns/1ps
// axi4-lite slave: captures one write and one read, hands them to the register file
module xcs_axil
	import xcs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic [7:0]  s_awaddr_i,
	input  wire logic        s_awvalid_i,
	output logic             s_awready_o,
	input  wire logic [31:0] s_wdata_i,
	input  wire logic [3:0]  s_wstrb_i,
	input  wire logic        s_wvalid_i,
	output logic             s_wready_o,
	output logic [1:0]       s_bresp_o,
	output logic             s_bvalid_o,
	input  wire logic        s_bready_i,
	input  wire logic [7:0]  s_araddr_i,
	input  wire logic        s_arvalid_i,
	output logic             s_arready_o,
	output logic [31:0]      s_rdata_o,
	output logic [1:0]       s_rresp_o,
	output logic             s_rvalid_o,
	input  wire logic        s_rready_i,
	output logic             wr_o,
	output logic [7:0]       wr_addr_o,
	output logic [31:0]      wr_data_o,
	output logic [3:0]       wr_strb_o,
	input  wire logic        wr_ok_i,
	output logic             rd_o,
	output logic [7:0]       rd_addr_o,
	input  wire logic [31:0] rd_data_i,
	input  wire logic        rd_ok_i
);
	typedef struct packed {
		logic        aw_f;
		logic [7:0]  aw;
		logic        w_f;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic        bv;
		logic [1:0]  br;
		logic        rv;
		logic [31:0] rd;
		logic [1:0]  rr;
	} xcs_axil_t;
	xcs_axil_t st_r;
	xcs_axil_t st_nxt;
	logic      do_wr;
	logic      do_rd;

	// write fires once both halves are held and no response is pending
	assign do_wr     = st_r.aw_f && st_r.w_f && !st_r.bv;
	assign do_rd     = s_arvalid_i && !st_r.rv;
	assign wr_o      = do_wr;
	assign wr_addr_o = st_r.aw;
	assign wr_data_o = st_r.wd;
	assign wr_strb_o = st_r.ws;
	assign rd_o      = do_rd;
	assign rd_addr_o = s_araddr_i;

	always_comb begin
		st_nxt = st_r;
		if (s_awvalid_i && !st_r.aw_f) begin
			st_nxt.aw_f = 1'b1;
			st_nxt.aw   = s_awaddr_i;
		end
		if (s_wvalid_i && !st_r.w_f) begin
			st_nxt.w_f = 1'b1;
			st_nxt.wd  = s_wdata_i;
			st_nxt.ws  = s_wstrb_i;
		end
		if (do_wr) begin
			st_nxt.aw_f = 1'b0;
			st_nxt.w_f  = 1'b0;
			st_nxt.bv   = 1'b1;
			st_nxt.br   = wr_ok_i ? XCS_RESP_OK : XCS_RESP_ERR;
		end
		if (st_r.bv && s_bready_i) begin
			st_nxt.bv = 1'b0;
		end
		if (st_r.rv && s_rready_i) begin
			st_nxt.rv = 1'b0;
		end
		if (do_rd) begin
			st_nxt.rv = 1'b1;
			st_nxt.rd = rd_data_i;
			st_nxt.rr = rd_ok_i ? XCS_RESP_OK : XCS_RESP_ERR;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_awready_o = !st_r.aw_f;
	assign s_wready_o  = !st_r.w_f;
	assign s_bvalid_o  = st_r.bv;
	assign s_bresp_o   = st_r.br;
	assign s_arready_o = !st_r.rv;
	assign s_rvalid_o  = st_r.rv;
	assign s_rdata_o   = st_r.rd;
	assign s_rresp_o   = st_r.rr;
endmodule

// ==== xcs_decoder.sv ====
`timescale 1ns/1ps
module xcs_decoder
	import xcs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic [7:0]  s_awaddr_i,
	input  wire logic        s_awvalid_i,
	output logic             s_awready_o,
	input  wire logic [31:0] s_wdata_i,
	input  wire logic [3:0]  s_wstrb_i,
	input  wire logic        s_wvalid_i,
	output logic             s_wready_o,
	output logic [1:0]       s_bresp_o,
	output logic             s_bvalid_o,
	input  wire logic        s_bready_i,
	input  wire logic [7:0]  s_araddr_i,
	input  wire logic        s_arvalid_i,
	output logic             s_arready_o,
	output logic [31:0]      s_rdata_o,
	output logic [1:0]       s_rresp_o,
	output logic             s_rvalid_o,
	input  wire logic        s_rready_i,
	input  wire logic        cyc_valid_i,
	input  wire logic        cyc_isa_i,
	input  wire logic [1:0]  cyc_type_i,
	input  wire logic [31:0] cyc_addr_i,
	input  wire logic        fpu_error_in_n_i,
	input  wire logic        irq12_in_i,
	input  wire logic        mouse_irq_i,
	input  wire logic        shared_a_in_n_i,
	input  wire logic        pci_reset_req_i,
	input  wire logic        ioapic_ack_req_i,
	output logic             ioapic_chip_select_n_o,
	output logic             bios_chip_select_n_o,
	output logic             keyboard_ctrl_select_n_o,
	output logic             rtc_chip_select_n_o,
	output logic             rtc_address_latch_o,
	output logic             xbus_output_enable_n_o,
	output logic             isa_forward_o,
	output logic [3:0]       isa_la_top_o,
	output logic             la_top_force_o,
	output logic             irq13_o,
	output logic             ignore_numeric_error_out_n_o,
	output logic             mouse_interrupt_line_o,
	output logic             test_input_n_o,
	output logic             ioapic_request_n_o,
	output logic             shared_b_out_n_o,
	output logic             irq_o
);
	typedef struct packed {
		logic [15:0] ctrl;
		logic [31:0] apic_base;
		logic [2:0]  stat;
		logic [2:0]  mask;
		logic        ioapic_cs;
		logic        bios_cs;
		logic        kbd_cs;
		logic        rtc_cs;
		logic        rtc_ale;
		logic        xoe;
		logic        fwd;
		logic        la_force;
		logic [3:0]  la_top;
		logic        irq13;
		logic        ign_n;
		logic        irq12;
		logic        test_n;
		logic        req_n;
		logic        b_n;
		logic        irq;
	} xcs_st_t;
	xcs_st_t     st_r;
	xcs_st_t     st_nxt;
	logic        wr;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        rd;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_ok;
	logic        wr_ok;
	logic        fpu_err;
	logic        shared_a_n;

	// address window test used by the bios window decodes and the rtc port decode
	function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	xcs_axil u_bus (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.s_awaddr_i  (s_awaddr_i),
		.s_awvalid_i (s_awvalid_i),
		.s_awready_o (s_awready_o),
		.s_wdata_i   (s_wdata_i),
		.s_wstrb_i   (s_wstrb_i),
		.s_wvalid_i  (s_wvalid_i),
		.s_wready_o  (s_wready_o),
		.s_bresp_o   (s_bresp_o),
		.s_bvalid_o  (s_bvalid_o),
		.s_bready_i  (s_bready_i),
		.s_araddr_i  (s_araddr_i),
		.s_arvalid_i (s_arvalid_i),
		.s_arready_o (s_arready_o),
		.s_rdata_o   (s_rdata_o),
		.s_rresp_o   (s_rresp_o),
		.s_rvalid_o  (s_rvalid_o),
		.s_rready_i  (s_rready_i),
		.wr_o        (wr),
		.wr_addr_o   (wr_addr),
		.wr_data_o   (wr_data),
		.wr_strb_o   (wr_strb),
		.wr_ok_i     (wr_ok),
		.rd_o        (rd),
		.rd_addr_o   (rd_addr),
		.rd_data_i   (rd_data),
		.rd_ok_i     (rd_ok)
	);

	// coprocessor error and shared a pin inputs pass two flops
	xcs_sync #(.W(2)) u_sync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    ({~fpu_error_in_n_i, shared_a_in_n_i}),
		.q_o    ({fpu_err, shared_a_n})
	);

	assign wr_ok = (wr_addr == XCS_OFS_CTRL) || (wr_addr == XCS_OFS_STAT) ||
		(wr_addr == XCS_OFS_MASK) || (wr_addr == XCS_OFS_IOAPIC);

	// register read mux
	always_comb begin
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		case (rd_addr)
			XCS_OFS_CTRL:   rd_data = {16'h0000, st_r.ctrl};
			XCS_OFS_STAT:   rd_data = {29'h0000_0000, st_r.stat};
			XCS_OFS_MASK:   rd_data = {29'h0000_0000, st_r.mask};
			XCS_OFS_IOAPIC: rd_data = st_r.apic_base;
			default:        rd_ok   = 1'b0;
		endcase
	end

	// decode and register update
	always_comb begin
		logic       pci;
		logic       mem;
		logic       wrc;
		logic       hit_apic;
		logic       hit_xb;
		logic       hit_lb;
		logic       hit_ab;
		logic       bios;
		logic       kbd;
		logic       rtc;
		logic [2:0] ev;
		logic [15:0] cm;
		pci      = cyc_valid_i && !cyc_isa_i;
		mem      = (cyc_type_i == XCS_CYC_MEMRD) || (cyc_type_i == XCS_CYC_MEMWR);
		wrc      = (cyc_type_i == XCS_CYC_MEMWR) || (cyc_type_i == XCS_CYC_IOWR);
		hit_apic = pci && mem && st_r.ctrl[XCS_B_IOAPIC] && ((cyc_addr_i == st_r.apic_base) ||
			(cyc_addr_i == st_r.apic_base + XCS_IOAPIC_STEP));
		hit_xb   = pci && mem && st_r.ctrl[XCS_B_XBIOS] &&
			in_rng(cyc_addr_i, XCS_XBIOS_LO, XCS_XBIOS_HI);
		hit_lb   = cyc_valid_i && mem && st_r.ctrl[XCS_B_LBIOS] &&
			in_rng(cyc_addr_i, XCS_LBIOS_LO, XCS_LBIOS_HI);
		hit_ab   = cyc_valid_i && mem && st_r.ctrl[XCS_B_LBIOS] &&
			in_rng(cyc_addr_i, XCS_ABIOS_LO, XCS_ABIOS_HI);
		bios     = (hit_xb || hit_lb || hit_ab) && (st_r.ctrl[XCS_B_BIOSWR] || !wrc);
		kbd      = cyc_valid_i && !mem && st_r.ctrl[XCS_B_KBD] &&
			((cyc_addr_i[15:0] == XCS_KBD_P0) || (cyc_addr_i[15:0] == XCS_KBD_P1)) &&
			(cyc_addr_i[31:16] == 16'h0000);
		rtc      = cyc_valid_i && !mem && st_r.ctrl[XCS_B_RTC] && (cyc_addr_i[31:16] == 16'h0000) &&
			in_rng({16'h0000, cyc_addr_i[15:0]}, {16'h0000, XCS_RTC_LO}, {16'h0000, XCS_RTC_HI});
		st_nxt           = st_r;
		st_nxt.ioapic_cs = hit_apic;
		st_nxt.bios_cs   = bios;
		st_nxt.kbd_cs    = kbd;
		st_nxt.rtc_cs    = rtc;
		st_nxt.rtc_ale   = rtc;
		st_nxt.xoe       = hit_apic || bios || kbd || rtc;
		st_nxt.fwd       = hit_apic || (pci && (hit_xb || hit_ab));
		st_nxt.la_force  = pci && (hit_xb || hit_ab);
		st_nxt.la_top    = (pci && (hit_xb || hit_ab)) ? XCS_LA_TOP : 4'h0;
		st_nxt.irq13     = st_r.ctrl[XCS_B_FPU] && fpu_err;
		st_nxt.ign_n     = !(st_r.ctrl[XCS_B_FPU] && fpu_err);
		st_nxt.irq12     = st_r.ctrl[XCS_B_MOUSE] ? mouse_irq_i : irq12_in_i;
		st_nxt.test_n    = st_r.ctrl[XCS_B_IOAPIC] ? 1'b1 : shared_a_n;
		st_nxt.req_n     = st_r.ctrl[XCS_B_IOAPIC] ? shared_a_n : 1'b1;
		st_nxt.b_n       = st_r.ctrl[XCS_B_IOAPIC] ? !ioapic_ack_req_i : !pci_reset_req_i;
		ev               = {wr && !wr_ok, hit_apic || bios || kbd || rtc, fpu_err && st_r.ctrl[XCS_B_FPU]};
		cm               = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & XCS_CTRL_WMSK;
		if (wr && wr_addr == XCS_OFS_CTRL) begin
			st_nxt.ctrl = (st_r.ctrl & ~cm) | (wr_data[15:0] & cm);
		end
		if (wr && wr_addr == XCS_OFS_MASK && wr_strb[0]) begin
			st_nxt.mask = wr_data[2:0];
		end
		if (wr && wr_addr == XCS_OFS_IOAPIC) begin
			for (int i = 0; i < 4; i++) begin
				if (wr_strb[i]) begin
					st_nxt.apic_base[i*8 +: 8] = wr_data[i*8 +: 8];
				end
			end
		end
		// write-one-to-clear, a new event wins
		if (wr && wr_addr == XCS_OFS_STAT && wr_strb[0]) begin
			st_nxt.stat = st_r.stat & ~wr_data[2:0];
		end
		st_nxt.stat = st_nxt.stat | ev;
		st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r           <= '0;
			st_r.ctrl      <= XCS_CTRL_RST;
			st_r.apic_base <= XCS_IOAPIC_RST;
			st_r.ign_n     <= 1'b1;
			st_r.test_n    <= 1'b1;
			st_r.req_n     <= 1'b1;
			st_r.b_n       <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// active-low selects come straight from state flops
	assign ioapic_chip_select_n_o       = !st_r.ioapic_cs;
	assign bios_chip_select_n_o         = !st_r.bios_cs;
	assign keyboard_ctrl_select_n_o     = !st_r.kbd_cs;
	assign rtc_chip_select_n_o          = !st_r.rtc_cs;
	assign rtc_address_latch_o          = st_r.rtc_ale;
	assign xbus_output_enable_n_o       = !st_r.xoe;
	assign isa_forward_o                = st_r.fwd;
	assign isa_la_top_o                 = st_r.la_top;
	assign la_top_force_o               = st_r.la_force;
	assign irq13_o                      = st_r.irq13;
	assign ignore_numeric_error_out_n_o = st_r.ign_n;
	assign mouse_interrupt_line_o       = st_r.irq12;
	assign test_input_n_o               = st_r.test_n;
	assign ioapic_request_n_o           = st_r.req_n;
	assign shared_b_out_n_o             = st_r.b_n;
	assign irq_o                        = st_r.irq;

	property p_isa_no_apic;
		@(posedge clk_i) disable iff (!nrst_i)
		(cyc_valid_i && cyc_isa_i) |=> ioapic_chip_select_n_o;
	endproperty
	a_isa_no_apic: assert property (p_isa_no_apic) else $error("ioapic select on isa cycle");

	property p_apic_off;
		@(posedge clk_i) disable iff (!nrst_i)
		!st_r.ctrl[XCS_B_IOAPIC] |=> ioapic_chip_select_n_o;
	endproperty
	a_apic_off: assert property (p_apic_off) else $error("ioapic select while disabled");

	property p_apic_hit;
		@(posedge clk_i) disable iff (!nrst_i)
		(cyc_valid_i && !cyc_isa_i && cyc_type_i == XCS_CYC_MEMRD && st_r.ctrl[XCS_B_IOAPIC] &&
			cyc_addr_i == st_r.apic_base) |=> (!ioapic_chip_select_n_o && !xbus_output_enable_n_o && isa_forward_o);
	endproperty
	a_apic_hit: assert property (p_apic_hit) else $error("ioapic hit missed");

	property p_xoe_needs_cs;
		@(posedge clk_i) disable iff (!nrst_i)
		!xbus_output_enable_n_o |-> (!ioapic_chip_select_n_o || !bios_chip_select_n_o ||
			!keyboard_ctrl_select_n_o || !rtc_chip_select_n_o);
	endproperty
	a_xoe_needs_cs: assert property (p_xoe_needs_cs) else $error("output enable without select");

	property p_bios_wp;
		@(posedge clk_i) disable iff (!nrst_i)
		(cyc_valid_i && cyc_type_i == XCS_CYC_MEMWR && !st_r.ctrl[XCS_B_BIOSWR]) |=> bios_chip_select_n_o;
	endproperty
	a_bios_wp: assert property (p_bios_wp) else $error("bios select on protected write");

	property p_la_top;
		@(posedge clk_i) disable iff (!nrst_i)
		la_top_force_o |-> (isa_la_top_o == 4'hf && isa_forward_o);
	endproperty
	a_la_top: assert property (p_la_top) else $error("upper latched address not all ones");

	property p_rtc;
		@(posedge clk_i) disable iff (!nrst_i)
		(cyc_valid_i && cyc_type_i == XCS_CYC_IORD && cyc_addr_i == 32'h0000_0077 && st_r.ctrl[XCS_B_RTC])
			|=> (!rtc_chip_select_n_o && rtc_address_latch_o && !xbus_output_enable_n_o);
	endproperty
	a_rtc: assert property (p_rtc) else $error("rtc decode missed");

	property p_kbd_off;
		@(posedge clk_i) disable iff (!nrst_i)
		!st_r.ctrl[XCS_B_KBD] |=> keyboard_ctrl_select_n_o;
	endproperty
	a_kbd_off: assert property (p_kbd_off) else $error("keyboard select while disabled");

	property p_fpu;
		@(posedge clk_i) disable iff (!nrst_i)
		(fpu_err && st_r.ctrl[XCS_B_FPU]) |=> (irq13_o && !ignore_numeric_error_out_n_o);
	endproperty
	a_fpu: assert property (p_fpu) else $error("fpu error not forwarded");

	property p_rsvd;
		@(posedge clk_i) disable iff (!nrst_i)
		(st_r.ctrl[15:9] == 7'h00) && !st_r.ctrl[3];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved control bit set");

	property p_xbios_off;
		@(posedge clk_i) disable iff (!nrst_i)
		(cyc_valid_i && !st_r.ctrl[XCS_B_XBIOS] && in_rng(cyc_addr_i, XCS_XBIOS_LO, XCS_XBIOS_HI))
			|=> bios_chip_select_n_o;
	endproperty
	a_xbios_off: assert property (p_xbios_off) else $error("extended bios select while disabled");

	property p_lbios_off;
		@(posedge clk_i) disable iff (!nrst_i)
		(cyc_valid_i && !st_r.ctrl[XCS_B_LBIOS] && !st_r.ctrl[XCS_B_IOAPIC] &&
			(in_rng(cyc_addr_i, XCS_LBIOS_LO, XCS_LBIOS_HI) || in_rng(cyc_addr_i, XCS_ABIOS_LO, XCS_ABIOS_HI)))
			|=> (bios_chip_select_n_o && !isa_forward_o);
	endproperty
	a_lbios_off: assert property (p_lbios_off) else $error("lower bios selected or forwarded while disabled");

	property p_kbd_hit;
		@(posedge clk_i) disable iff (!nrst_i)
		(cyc_valid_i && cyc_type_i == XCS_CYC_IORD && cyc_addr_i == {16'h0000, XCS_KBD_P0} && st_r.ctrl[XCS_B_KBD])
			|=> (!keyboard_ctrl_select_n_o && !xbus_output_enable_n_o);
	endproperty
	a_kbd_hit: assert property (p_kbd_hit) else $error("keyboard decode missed");
endmodule

// ==== xcs_xbus_model.sv ====
`timescale 1ns/1ps
// x-bus side model: drives the coprocessor error and shared request pins, plus an isa memory board decode
module xcs_xbus_model
	import xcs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        fpu_req_i,
	input  wire logic        shared_req_i,
	input  wire logic [31:0] cyc_addr_i,
	output logic             fpu_error_in_n_o,
	output logic             shared_a_in_n_o,
	output logic             board_sel_o
);
	// pins are active low and sit high while nothing is requested
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fpu_error_in_n_o <= 1'b1;
			shared_a_in_n_o  <= 1'b1;
		end else begin
			fpu_error_in_n_o <= ~fpu_req_i;
			shared_a_in_n_o  <= ~shared_req_i;
		end
	end
	// add-in memory at 8-16 mbyte keeps clear of the aliased bios window
	assign board_sel_o = (cyc_addr_i[31:23] == 9'h001) &&
		!((cyc_addr_i >= 32'h00f8_0000) && (cyc_addr_i <= 32'h00fd_ffff));
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
// self-checking bench for the x-bus chip select decoder
module tb_top;
	import xcs_pkg::*;
	typedef struct {logic [15:0] c; logic isa; logic [1:0] t; logic [31:0] a; logic [7:0] m; logic [7:0] e;} xcs_row_t;
	logic clk_i, nrst_i, awvalid, wvalid, bready, arvalid, rready, cyc_valid, cyc_isa;
	logic fpu_req, shared_req, irq12_in, mouse_irq, pci_rst_req, ack_req;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, cyc_addr, rd;
	logic [3:0] wstrb;
	logic [1:0] cyc_type, rsp;
	wire awready, wready, bvalid, arready, rvalid, ioa_n, bios_n, kbd_n, rtc_n, ale, xoe_n, fwd, force_la;
	wire irq13, ign_n, mouse_line, test_n, req_n, sh_b_n, irq, fpu_n, sh_a_n, board_sel;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [3:0] la_top;
	wire [7:0] obs = {ioa_n, bios_n, kbd_n, rtc_n, ale, xoe_n, fwd, force_la};
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	logic irq_a;
	// decode table: control value, master, cycle type, address, compare mask, expected outputs
	xcs_row_t rows [21] = '{
		'{16'h0003, 0, 2, 32'h60, 8'hff, 8'hd0}, '{16'h0003, 0, 3, 32'h64, 8'hff, 8'hd0},
		'{16'h0003, 0, 2, 32'h70, 8'hff, 8'he8}, '{16'h0003, 0, 3, 32'h77, 8'hff, 8'he8},
		'{16'h0003, 0, 2, 32'h78, 8'hff, 8'hf4}, '{16'h0000, 0, 2, 32'h60, 8'hff, 8'hf4},
		'{16'h0000, 0, 2, 32'h72, 8'hff, 8'hf4}, '{16'h0100, 0, 0, 32'hfec0_0000, 8'hff, 8'h72},
		'{16'h0100, 0, 1, 32'hfec0_0010, 8'hff, 8'h72}, '{16'h0100, 1, 0, 32'hfec0_0000, 8'h80, 8'h80},
		'{16'h0000, 0, 0, 32'hfec0_0000, 8'hff, 8'hf4}, '{16'h0080, 0, 0, 32'hfff8_0000, 8'hff, 8'hb3},
		'{16'h0080, 0, 0, 32'hfffd_ffff, 8'hff, 8'hb3}, '{16'h0080, 0, 0, 32'hfffe_0000, 8'hff, 8'hf4},
		'{16'h0000, 0, 0, 32'hfff8_0000, 8'hff, 8'hf4}, '{16'h0040, 0, 0, 32'h000e_0000, 8'hff, 8'hb0},
		'{16'h0040, 1, 0, 32'h000e_ffff, 8'hff, 8'hb0}, '{16'h0040, 0, 0, 32'hfffe_0000, 8'hff, 8'hb3},
		'{16'h0040, 0, 1, 32'h000e_0000, 8'h40, 8'h40}, '{16'h0044, 0, 1, 32'h000e_0000, 8'hff, 8'hb0},
		'{16'h0080, 0, 0, 32'hfff7_ffff, 8'hff, 8'hf4}};

	xcs_decoder xcs_decoder_i (.clk_i(clk_i), .nrst_i(nrst_i), .s_awaddr_i(awaddr), .s_awvalid_i(awvalid),
		.s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid), .s_wready_o(wready),
		.s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
		.s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready),
		.cyc_valid_i(cyc_valid), .cyc_isa_i(cyc_isa), .cyc_type_i(cyc_type), .cyc_addr_i(cyc_addr),
		.fpu_error_in_n_i(fpu_n), .irq12_in_i(irq12_in), .mouse_irq_i(mouse_irq), .shared_a_in_n_i(sh_a_n),
		.pci_reset_req_i(pci_rst_req), .ioapic_ack_req_i(ack_req), .ioapic_chip_select_n_o(ioa_n),
		.bios_chip_select_n_o(bios_n), .keyboard_ctrl_select_n_o(kbd_n), .rtc_chip_select_n_o(rtc_n),
		.rtc_address_latch_o(ale), .xbus_output_enable_n_o(xoe_n), .isa_forward_o(fwd), .isa_la_top_o(la_top),
		.la_top_force_o(force_la), .irq13_o(irq13), .ignore_numeric_error_out_n_o(ign_n),
		.mouse_interrupt_line_o(mouse_line), .test_input_n_o(test_n), .ioapic_request_n_o(req_n),
		.shared_b_out_n_o(sh_b_n), .irq_o(irq));
	xcs_xbus_model xcs_xbus_model_i (.clk_i(clk_i), .nrst_i(nrst_i), .fpu_req_i(fpu_req), .shared_req_i(shared_req),
		.cyc_addr_i(cyc_addr), .fpu_error_in_n_o(fpu_n), .shared_a_in_n_o(sh_a_n), .board_sel_o(board_sel));

	// clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// axi4-lite write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// one bus cycle for one clock, outputs looked at after the following edge
	task automatic cyc(input logic isa, input logic [1:0] t, input logic [31:0] a);
		@(posedge clk_i);
		cyc_valid <= 1'b1;
		cyc_isa <= isa;
		cyc_type <= t;
		cyc_addr <= a;
		@(posedge clk_i);
		cyc_valid <= 1'b0;
		#1;
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, cyc_valid, cyc_isa} = '0;
		{fpu_req, shared_req, irq12_in, mouse_irq, pci_rst_req, ack_req} = '0;
		{awaddr, araddr, wdata, cyc_addr, cyc_type} = '0;
		wstrb = 4'hf;
		nrst_i = 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		foreach (rows[i]) begin
			axi_wr(XCS_OFS_CTRL, {16'h0, rows[i].c}, rsp);
			cyc(rows[i].isa, rows[i].t, rows[i].a);
			check("decode", obs & rows[i].m, rows[i].e);
			check("la top", la_top, rows[i].e[0] ? 32'hf : 32'h0);
		end
		// reset in mid-run
		@(posedge clk_i);
		nrst_i <= 1'b0;
		#1;
		check("reset outs", {obs, irq}, {8'hf4, 1'b0});
		@(posedge clk_i);
		nrst_i <= 1'b1;
		axi_rd(XCS_OFS_CTRL, rd, rsp);
		check("ctrl reset", rd, 32'h0003);
		check("rd resp", rsp, XCS_RESP_OK);
		axi_rd(XCS_OFS_IOAPIC, rd, rsp);
		check("base reset", rd, XCS_IOAPIC_RST);
		axi_rd(XCS_OFS_STAT, rd, rsp);
		check("stat reset", rd, 32'h0);
		// reserved control bits and an unmapped address
		axi_wr(XCS_OFS_CTRL, 32'hffff_ffff, rsp);
		check("wr resp", rsp, XCS_RESP_OK);
		axi_rd(XCS_OFS_CTRL, rd, rsp);
		check("ctrl reserved", rd, 32'h01f7);
		axi_wr(8'h10, 32'h1, rsp);
		check("unmapped wr", rsp, XCS_RESP_ERR);
		axi_rd(8'h10, rd, rsp);
		check("unmapped rd", rsp, XCS_RESP_ERR);
		// relocated interrupt controller region
		axi_wr(XCS_OFS_CTRL, 32'h0100, rsp);
		axi_wr(XCS_OFS_IOAPIC, 32'hfec0_1000, rsp);
		cyc(1'b0, 2'd0, 32'hfec0_1000);
		check("reloc hit", obs, 8'h72);
		cyc(1'b0, 2'd0, 32'hfec0_0000);
		check("reloc old", obs, 8'hf4);
		// isa add-in board keeps off the aliased bios window
		cyc(1'b1, 2'd0, 32'h00f8_0000);
		check("board alias", {board_sel, obs}, {1'b0, 8'hf4});
		cyc(1'b1, 2'd0, 32'h0080_0000);
		check("board plain", board_sel, 1'b1);
		// shared pin roles
		shared_req <= 1'b1;
		pci_rst_req <= 1'b1;
		axi_wr(XCS_OFS_CTRL, 32'h0000, rsp);
		ticks(5);
		check("shared 0", {test_n, req_n, sh_b_n}, 3'b010);
		axi_wr(XCS_OFS_CTRL, 32'h0100, rsp);
		ticks(5);
		check("shared 1", {test_n, req_n, sh_b_n}, 3'b101);
		ack_req <= 1'b1;
		ticks(3);
		check("shared ack", sh_b_n, 1'b0);
		// coprocessor error and interrupt status
		axi_wr(XCS_OFS_CTRL, 32'h0020, rsp);
		fpu_req <= 1'b1;
		ticks(6);
		check("fpu on", {irq13, ign_n}, 2'b10);
		fpu_req <= 1'b0;
		ticks(6);
		check("fpu off", {irq13, ign_n}, 2'b01);
		axi_rd(XCS_OFS_STAT, rd, rsp);
		check("stat events", rd, 32'h7);
		axi_wr(XCS_OFS_MASK, 32'h1, rsp);
		axi_rd(XCS_OFS_MASK, rd, rsp);
		check("mask rw", rd, 32'h1);
		ticks(2);
		irq_a = irq;
		axi_wr(XCS_OFS_MASK, 32'h0, rsp);
		ticks(2);
		check("mask on", irq_a, 1'b1);
		check("mask off", irq, 1'b0);
		axi_wr(XCS_OFS_MASK, 32'h7, rsp);
		check("irq set", irq, 1'b1);
		axi_wr(XCS_OFS_STAT, 32'h7, rsp);
		axi_rd(XCS_OFS_STAT, rd, rsp);
		check("stat clear", rd, 32'h0);
		check("irq clear", irq, 1'b0);
		// line 12 source select
		mouse_irq <= 1'b1;
		axi_wr(XCS_OFS_CTRL, 32'h0010, rsp);
		ticks(3);
		check("mouse on", mouse_line, 1'b1);
		axi_wr(XCS_OFS_CTRL, 32'h0000, rsp);
		ticks(3);
		check("mouse off", mouse_line, 1'b0);
		tally_and_finish();
	end
endmodule
